// [motion_cmd_pkg.sv]
package motion_cmd_pkg;

  localparam int FRAME_BYTES = 9;
  localparam logic [7:0] OP_MOVE_TO_POSITION = 8'h04;
  localparam logic [7:0] OP_SET_AXIS = 8'h05;
  localparam logic [7:0] OP_GET_AXIS = 8'h06;
  localparam logic [7:0] OP_SET_GLOBAL = 8'h09;
  localparam logic [7:0] OP_GET_GLOBAL = 8'h0A;
  localparam logic [7:0] OP_PERSIST_GLOBAL = 8'h0B;
  localparam logic [7:0] MOVE_TYPE_POINT = 8'h02;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_OPCODE = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  localparam int SEL_INDEPENDENT_BIT = 7;
  localparam int SEL_INTERP_BIT = 6;
  localparam logic [7:0] BANK_MODULE = 8'h00;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] BANK_IRQ = 8'h03;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [7:0] DEFAULT_ADDRESS = 8'h01;

  typedef struct packed {
    logic [7:0] address;
    logic [7:0] opcode;
    logic [7:0] ptype;
    logic [7:0] motor;
    logic [31:0] value;
  } frame_s;

  typedef struct packed {
    logic [7:0] address;
    logic [7:0] status;
    logic [7:0] opcode;
    logic [31:0] value;
  } reply_s;

  typedef struct packed {
    logic [2:0] motors;
    logic interpolate;
    logic [7:0] point;
  } move_s;

  typedef struct packed {
    logic [1:0] bank;
    logic [7:0] index;
    logic [31:0] value;
  } nv_req_s;

endpackage

// [param_store.sv]
`timescale 1ns/1ps
module param_store #(
  parameter int ENTRIES = 256,
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic ld_i,
  input wire logic [AW-1:0] laddr_i,
  input wire logic [31:0] ldata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [31:0] rdata_o
);
  import motion_cmd_pkg::*;

  if (ENTRIES > (1 << AW) || ENTRIES < 1) begin : g_bad
    $error("param_store: ENTRIES does not fit AW");
  end

  // Volatile working storage, lost on power cycle
  logic [31:0] mem [ENTRIES];

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end else if (ld_i) begin
      mem[laddr_i] <= ldata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= VALUE_RESET;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// [motion_param_command_decoder.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - A single-motor point move carries motor number 0 to 2, flags clear.
// - Bit 7 of the motor field starts each motor in bits 0-2 on its own.
// - Bit 6 of the motor field moves the motors in bits 0-2 interpolated.
// - Opcode 5 writes the value into the axis parameter of type and motor.
// - Axis parameters sit only in volatile storage.
// - Opcode 6 from a standalone program also loads the accumulator.
// - Opcode 6 in direct mode replies the value, accumulator untouched.
// - Opcode 9 writes the value to the parameter of type in bank 0, 2 or 3.
// - Bank 0 is module settings, bank 2 user variables, bank 3 irq setup.
// - Any bank 0 write is also sent to non-volatile memory.
// - Opcode 10 ignores the value, loads the accumulator and replies it.
// - Opcode 11 copies the selected global parameter to non-volatile memory.
// - After reset user variables are restored from non-volatile memory if auto_restore_i or restore_req_i is set
module motion_param_command_decoder #(
  parameter int MOTORS = 3,
  parameter int AXIS_TYPES = 256,
  parameter int GLOBAL_TYPES = 256
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic prog_valid_i,
  input wire motion_cmd_pkg::frame_s prog_cmd_i,
  output logic prog_ready_o,
  input wire logic auto_restore_i,
  input wire logic restore_req_i,
  input wire logic nv_ready_i,
  input wire logic nv_rdata_valid_i,
  input wire logic [31:0] nv_rdata_i,
  output motion_cmd_pkg::nv_req_s nv_req_o,
  output logic nv_write_o,
  output logic nv_read_o,
  output logic restore_busy_o,
  output motion_cmd_pkg::move_s move_o,
  output logic move_start_o,
  output logic [31:0] accumulator_o,
  output motion_cmd_pkg::reply_s reply_o,
  output logic reply_valid_o,
  input wire logic reply_ready_i
);
  import motion_cmd_pkg::*;
  if (MOTORS != 3 || AXIS_TYPES > 256 || GLOBAL_TYPES > 256) begin : g_bad
    $error("motion_param_command_decoder: unsupported parameters");
  end

  typedef enum logic [2:0] {
    ST_RESTORE = 3'b000,
    ST_RECV = 3'b001,
    ST_EXEC = 3'b010,
    ST_READ = 3'b011,
    ST_NV = 3'b100,
    ST_REPLY = 3'b101
  } state_e;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  state_e state_ff, nxt_state;
  logic [3:0] cnt_ff;
  logic [7:0] sum_ff;
  frame_s frame_ff;
  logic from_prog_ff;
  logic [31:0] acc_ff;
  reply_s reply_ff;
  move_s move_ff;
  logic move_start_ff;
  nv_req_s nv_req_ff;
  logic nv_write_ff;
  logic nv_read_ff;
  logic [7:0] rst_idx_ff;
  logic rst_wait_ff;
  logic rst_started_ff;
  logic rx_s1_ff, rx_s2_ff, rx_s3_ff;
  logic [7:0] byte_s1_ff, byte_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Link input synchroniser
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_s1_ff <= 1'b0;
      rx_s2_ff <= 1'b0;
      rx_s3_ff <= 1'b0;
      byte_s1_ff <= 8'h00;
      byte_s2_ff <= 8'h00;
    end else begin
      rx_s1_ff <= rx_valid_i;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
      byte_s1_ff <= rx_byte_i;
      byte_s2_ff <= byte_s1_ff;
    end
  end
  wire rx_pulse = rx_s2_ff & ~rx_s3_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire byte_in = (state_ff == ST_RECV) & rx_pulse;
  wire last_byte = byte_in & (cnt_ff == 4'(FRAME_BYTES - 1));
  wire take_prog = (state_ff == ST_RECV) & prog_valid_i & (cnt_ff == 4'h0);
  wire sum_ok = (sum_ff == byte_s2_ff);
  wire [7:0] op = frame_ff.opcode;
  wire [7:0] bank = frame_ff.motor;
  wire motor_ok = frame_ff.motor < 8'(MOTORS);
  wire bank_ok = (bank == BANK_MODULE) | (bank == BANK_USER)
    | (bank == BANK_IRQ);
  wire is_set_axis = (op == OP_SET_AXIS);
  wire is_get_axis = (op == OP_GET_AXIS);
  wire is_set_glob = (op == OP_SET_GLOBAL);
  wire is_get_glob = (op == OP_GET_GLOBAL);
  wire is_persist = (op == OP_PERSIST_GLOBAL);
  wire is_move = (op == OP_MOVE_TO_POSITION)
    & (frame_ff.ptype == MOVE_TYPE_POINT);
  wire sel_indep = frame_ff.motor[SEL_INDEPENDENT_BIT];
  wire sel_interp = frame_ff.motor[SEL_INTERP_BIT];
  wire multi = sel_indep | sel_interp;
  wire [2:0] single_mask = 3'b001 << frame_ff.motor[1:0];
  wire move_ok = multi ? (frame_ff.motor[5:3] == 3'b000)
    & (|frame_ff.motor[2:0]) & ~(sel_indep & sel_interp) : motor_ok;
  wire [2:0] move_mask = multi ? frame_ff.motor[2:0] : single_mask;
  wire axis_cmd = is_set_axis | is_get_axis;
  wire glob_cmd = is_set_glob | is_get_glob | is_persist;
  wire cmd_known = axis_cmd | glob_cmd | is_move;
  wire args_ok = axis_cmd ? motor_ok : glob_cmd ? bank_ok : move_ok;
  wire exec_ok = cmd_known & args_ok;
  wire [7:0] bad_status = !cmd_known ? STATUS_BAD_OPCODE
    : is_move ? STATUS_BAD_VALUE : STATUS_BAD_TYPE;

  // Axis address: motor and type; global address: bank and type
  wire [9:0] axis_addr = {frame_ff.motor[1:0], frame_ff.ptype};
  wire [9:0] glob_addr = {bank[1:0], frame_ff.ptype};
  wire restoring = (state_ff == ST_RESTORE);
  wire axis_wr = (state_ff == ST_EXEC) & is_set_axis & exec_ok;
  wire glob_wr = (state_ff == ST_EXEC) & is_set_glob & exec_ok;
  wire rst_ld = restoring & nv_rdata_valid_i;
  wire [31:0] axis_rdata, glob_rdata;
  wire [9:0] rst_addr = {BANK_USER[1:0], rst_idx_ff};

  param_store #(.ENTRIES(1024), .AW(10)) axis_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(axis_wr),
    .waddr_i(axis_addr),
    .wdata_i(frame_ff.value),
    .ld_i(1'b0),
    .laddr_i(10'h000),
    .ldata_i(32'h0000_0000),
    .raddr_i(axis_addr),
    .rdata_o(axis_rdata)
  );

  param_store #(.ENTRIES(1024), .AW(10)) glob_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(glob_wr),
    .waddr_i(glob_addr),
    .wdata_i(frame_ff.value),
    .ld_i(rst_ld),
    .laddr_i(rst_addr),
    .ldata_i(nv_rdata_i),
    .raddr_i(glob_addr),
    .rdata_o(glob_rdata)
  );

  wire [31:0] read_val = axis_cmd ? axis_rdata : glob_rdata;
  wire needs_read = exec_ok & (is_get_axis | is_get_glob | is_persist);
  wire needs_nv = exec_ok & ((is_set_glob & (bank == BANK_MODULE))
    | is_persist);
  wire restore_done = rst_wait_ff & nv_rdata_valid_i
    & (rst_idx_ff == 8'(GLOBAL_TYPES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // State machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESTORE: begin
        if (!rst_started_ff) begin
          nxt_state = ST_RESTORE;
        end else if (restore_done) begin
          nxt_state = ST_RECV;
        end
      end
      ST_RECV: begin
        if (take_prog) begin
          nxt_state = ST_EXEC;
        end else if (last_byte) begin
          nxt_state = sum_ok ? ST_EXEC : ST_REPLY;
        end else if (restore_req_i && cnt_ff == 4'h0) begin
          nxt_state = ST_RESTORE;
        end
      end
      ST_EXEC: begin
        nxt_state = needs_read ? ST_READ : needs_nv ? ST_NV : ST_REPLY;
      end
      ST_READ: begin
        nxt_state = is_persist ? ST_NV : ST_REPLY;
      end
      ST_NV: begin
        if (nv_ready_i) begin
          nxt_state = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (from_prog_ff || reply_ready_i) begin
          nxt_state = ST_RECV;
        end
      end
      default: begin
        nxt_state = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_RESTORE;
      rst_started_ff <= 1'b0;
      rst_idx_ff <= 8'h00;
      rst_wait_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (!restoring) begin
        rst_started_ff <= 1'b0;
        rst_idx_ff <= 8'h00;
        rst_wait_ff <= 1'b0;
      end else if (!rst_started_ff) begin
        rst_started_ff <= 1'b1;
        if (!auto_restore_i && !restore_req_i) begin
          state_ff <= ST_RECV;
        end
      end else if (!rst_wait_ff && nv_ready_i) begin
        rst_wait_ff <= 1'b1;
      end else if (nv_rdata_valid_i) begin
        rst_wait_ff <= 1'b0;
        rst_idx_ff <= rst_idx_ff + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_ff != ST_RECV) begin
      cnt_ff <= 4'h0;
      sum_ff <= 8'h00;
    end else if (byte_in) begin
      cnt_ff <= last_byte ? 4'h0 : cnt_ff + 4'h1;
      sum_ff <= sum_ff + byte_s2_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      frame_ff <= '0;
      from_prog_ff <= 1'b0;
    end else if (take_prog) begin
      frame_ff <= prog_cmd_i;
      from_prog_ff <= 1'b1;
    end else if (byte_in && !last_byte) begin
      frame_ff <= {frame_ff[55:0], byte_s2_ff};
      from_prog_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution results
  wire load_acc = (state_ff == ST_READ) & (is_get_glob
    | (is_get_axis & from_prog_ff));
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_ff <= VALUE_RESET;
      reply_ff <= '0;
      move_ff <= '0;
      move_start_ff <= 1'b0;
    end else begin
      move_start_ff <= 1'b0;
      if (load_acc) begin
        acc_ff <= read_val;
      end
      if (state_ff == ST_RECV && last_byte && !sum_ok) begin
        reply_ff <= {DEFAULT_ADDRESS, STATUS_BAD_CHECKSUM, op, VALUE_RESET};
      end else if (state_ff == ST_EXEC) begin
        reply_ff <= {DEFAULT_ADDRESS, exec_ok ? STATUS_OK : bad_status,
          op, VALUE_RESET};
        if (exec_ok && is_move) begin
          move_ff <= {move_mask, sel_interp,
            frame_ff.value[7:0]};
          move_start_ff <= 1'b1;
        end
      end else if (state_ff == ST_READ && !is_persist) begin
        reply_ff.value <= read_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Non-volatile requests
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      nv_req_ff <= '0;
      nv_write_ff <= 1'b0;
      nv_read_ff <= 1'b0;
    end else begin
      nv_write_ff <= 1'b0;
      nv_read_ff <= 1'b0;
      if (state_ff == ST_EXEC && needs_nv && !is_persist) begin
        nv_req_ff <= {bank[1:0], frame_ff.ptype, frame_ff.value};
      end else if (state_ff == ST_READ && is_persist) begin
        nv_req_ff <= {bank[1:0], frame_ff.ptype, read_val};
      end else if (restoring && rst_started_ff) begin
        nv_req_ff <= {BANK_USER[1:0], rst_idx_ff, VALUE_RESET};
      end
      if (nxt_state == ST_NV && state_ff != ST_NV) begin
        nv_write_ff <= 1'b1;
      end
      if (restoring && rst_started_ff && !rst_wait_ff && nv_ready_i) begin
        nv_read_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign prog_ready_o = take_prog;
  assign nv_req_o = nv_req_ff;
  assign nv_write_o = nv_write_ff;
  assign nv_read_o = nv_read_ff;
  assign restore_busy_o = restoring;
  assign move_o = move_ff;
  assign move_start_o = move_start_ff;
  assign accumulator_o = acc_ff;
  assign reply_o = reply_ff;
  assign reply_valid_o = (state_ff == ST_REPLY) & ~from_prog_ff;
endmodule

// [decoder_chk.sv]
`timescale 1ns/1ps
module decoder_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic prog_ready_o,
  input wire motion_cmd_pkg::nv_req_s nv_req_o,
  input wire logic nv_write_o,
  input wire logic nv_read_o,
  input wire logic restore_busy_o,
  input wire motion_cmd_pkg::move_s move_o,
  input wire logic move_start_o,
  input wire logic [31:0] accumulator_o,
  input wire motion_cmd_pkg::reply_s reply_o,
  input wire logic reply_valid_o,
  input wire logic reply_ready_i
);
  import motion_cmd_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  reply_hold_a: assert property (
    reply_valid_o && !reply_ready_i |=> reply_valid_o && $stable(reply_o))
    else $error("reply dropped");
  reply_addr_a: assert property (
    reply_valid_o |-> reply_o.address == DEFAULT_ADDRESS)
    else $error("reply address");
  move_reply_a: assert property (
    move_start_o && !$past(prog_ready_o, 2) |-> ##[0:2] (reply_valid_o
    && reply_o.status == STATUS_OK && reply_o.opcode == OP_MOVE_TO_POSITION))
    else $error("move no reply");
  move_sel_a: assert property (
    move_start_o |-> move_o.motors != 3'h0 ##1 !move_start_o)
    else $error("bad move start");
  nv_bank_a: assert property (
    nv_write_o |-> nv_req_o.bank == 2'h0 || nv_req_o.bank == 2'h2)
    else $error("nv write bank");
  nv_read_a: assert property (
    nv_read_o |-> restore_busy_o && nv_req_o.bank == 2'h2)
    else $error("nv read outside restore");
  acc_cause_a: assert property (
    $changed(accumulator_o) && !$past(prog_ready_o, 3) |-> ##[0:1]
    (reply_valid_o && reply_o.opcode == OP_GET_GLOBAL))
    else $error("accumulator changed");
  prog_quiet_a: assert property (
    prog_ready_o |-> !reply_valid_o ##1 !reply_valid_o ##1 !reply_valid_o
    ##1 !reply_valid_o) else $error("program command replied");
  busy_quiet_a: assert property (
    restore_busy_o |-> !reply_valid_o && !move_start_o)
    else $error("activity during restore");
  cover property (move_start_o && move_o.interpolate);
  cover property (nv_write_o && nv_req_o.bank == 2'h2);
  cover property (reply_valid_o && reply_o.status == STATUS_BAD_CHECKSUM);
endmodule
bind motion_param_command_decoder decoder_chk u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .prog_ready_o(prog_ready_o), .nv_req_o(nv_req_o),
  .nv_write_o(nv_write_o), .nv_read_o(nv_read_o),
  .restore_busy_o(restore_busy_o), .move_o(move_o),
  .move_start_o(move_start_o), .accumulator_o(accumulator_o),
  .reply_o(reply_o), .reply_valid_o(reply_valid_o),
  .reply_ready_i(reply_ready_i));

// [host_link_model.sv]
`timescale 1ns/1ps
module host_link_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire motion_cmd_pkg::reply_s reply_i,
  input wire logic reply_valid_i,
  input wire motion_cmd_pkg::nv_req_s nv_req_i,
  input wire logic nv_write_i,
  input wire logic nv_read_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic reply_ready_o,
  output logic nv_ready_o,
  output logic nv_rdata_valid_o,
  output logic [31:0] nv_rdata_o
);
  import motion_cmd_pkg::*;
  int wait_q = 0;
  int n_wr = 0;
  logic rd_q = 1'h0;
  logic [7:0] idx_q = 8'h00;
  nv_req_s wr_last = '0;
  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'h0;
    reply_ready_o = 1'h0;
    nv_ready_o = 1'h1;
    nv_rdata_valid_o = 1'h0;
    nv_rdata_o = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Slow memory: stalls after each request
  always @(posedge clk_i) begin
    wait_q <= !rst_n_i ? 0 : nv_read_i ? 3 : nv_write_i ? 5 :
      (wait_q > 0 ? wait_q - 1 : 0);
    nv_ready_o <= !(nv_read_i || nv_write_i) && wait_q <= 1;
    rd_q <= nv_read_i ? 1'h1 : (wait_q == 1 ? 1'h0 : rd_q);
    idx_q <= nv_read_i ? nv_req_i.index : idx_q;
    nv_rdata_valid_o <= wait_q == 1 && rd_q;
    nv_rdata_o <= (wait_q == 1 && rd_q) ? {24'h00A5C3, idx_q} : ~nv_rdata_o;
    if (nv_write_i) begin
      n_wr <= n_wr + 1;
      wr_last <= nv_req_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk_i);
    rx_byte_o <= b;
    rx_valid_o <= 1'h1;
    repeat (4) @(posedge clk_i);
    rx_valid_o <= 1'h0;
    rx_byte_o <= ~b;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic send_frame(input logic [7:0] op, ty, mb,
      input logic [31:0] v, input logic bad);
    logic [7:0] f [8];
    logic [7:0] sum;
    f = '{DEFAULT_ADDRESS, op, ty, mb, v[31:24], v[23:16], v[15:8], v[7:0]};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sum = sum + f[i];
      send_byte(f[i]);
    end
    send_byte(sum + {7'h00, bad});
  endtask
  task automatic take_reply(output reply_s r, output logic ok);
    ok = 1'h0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge clk_i);
      ok = reply_valid_i === 1'h1;
    end
    r = reply_i;
    reply_ready_o <= 1'h1;
    @(posedge clk_i);
    reply_ready_o <= 1'h0;
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import motion_cmd_pkg::*;
  logic clk_i, rst_n_i, rx_valid_i, prog_valid_i, prog_ready_o;
  logic auto_restore_i, restore_req_i, nv_ready_i, nv_rdata_valid_i;
  logic nv_write_o, nv_read_o, restore_busy_o, move_start_o;
  logic reply_valid_o, reply_ready_i;
  logic [7:0] rx_byte_i;
  logic [31:0] nv_rdata_i, accumulator_o;
  frame_s prog_cmd_i;
  nv_req_s nv_req_o;
  move_s move_o, mv_last;
  reply_s reply_o;
  int failures = 0;
  int n_tests = 0;
  int mv_seen = 0;
  always #12.5 clk_i = ~clk_i;
  motion_param_command_decoder u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i),
    .prog_valid_i(prog_valid_i), .prog_cmd_i(prog_cmd_i),
    .prog_ready_o(prog_ready_o), .auto_restore_i(auto_restore_i),
    .restore_req_i(restore_req_i), .nv_ready_i(nv_ready_i),
    .nv_rdata_valid_i(nv_rdata_valid_i), .nv_rdata_i(nv_rdata_i),
    .nv_req_o(nv_req_o), .nv_write_o(nv_write_o), .nv_read_o(nv_read_o),
    .restore_busy_o(restore_busy_o), .move_o(move_o),
    .move_start_o(move_start_o), .accumulator_o(accumulator_o),
    .reply_o(reply_o), .reply_valid_o(reply_valid_o),
    .reply_ready_i(reply_ready_i));
  host_link_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reply_i(reply_o), .reply_valid_i(reply_valid_o), .nv_req_i(nv_req_o),
    .nv_write_i(nv_write_o), .nv_read_i(nv_read_o), .rx_byte_o(rx_byte_i),
    .rx_valid_o(rx_valid_i), .reply_ready_o(reply_ready_i),
    .nv_ready_o(nv_ready_i), .nv_rdata_valid_o(nv_rdata_valid_i),
    .nv_rdata_o(nv_rdata_i));
  always @(posedge clk_i) begin
    if (move_start_o === 1'h1) begin
      mv_seen <= mv_seen + 1;
      mv_last <= move_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'h1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic do_cmd(input logic [7:0] op, ty, mb, input logic [31:0] v,
      input logic bad, output reply_s r);
    logic ok;
    u_host.send_frame(op, ty, mb, v, bad);
    u_host.take_reply(r, ok);
    check(ok, "no reply");
  endtask
  task automatic t_restore;
    reply_s r;
    check(restore_busy_o === 1'h1, "no restore");
    for (int i = 0; i < 4000 && restore_busy_o !== 1'h0; i++) @(posedge clk_i);
    do_cmd(OP_GET_GLOBAL, 8'h07, BANK_USER, 32'hDEAD_BEEF, 1'h0, r);
    check(r.value === 32'h00A5_C307, "restored value");
    check(accumulator_o === 32'h00A5_C307, "acc load");
  endtask
  task automatic t_axis;
    reply_s r;
    int w;
    logic [31:0] acc;
    w = u_host.n_wr;
    do_cmd(OP_SET_AXIS, 8'h04, 8'h02, 32'h0000_C800, 1'h0, r);
    check(r.status === STATUS_OK && r.opcode === OP_SET_AXIS, "set");
    acc = accumulator_o;
    do_cmd(OP_GET_AXIS, 8'h04, 8'h02, 32'h0, 1'h0, r);
    check(r.value === 32'h0000_C800, "axis readback");
    check(accumulator_o === acc, "acc touched");
    check(u_host.n_wr == w, "axis stored");
    do_cmd(OP_SET_AXIS, 8'h04, 8'h02, 32'h1111_1111, 1'h1, r);
    check(r.status === STATUS_BAD_CHECKSUM, "checksum");
    do_cmd(OP_GET_AXIS, 8'h04, 8'h02, 32'h0, 1'h0, r);
    check(r.value === 32'h0000_C800, "bad frame ran");
  endtask
  task automatic t_prog;
    logic got;
    got = 1'h0;
    prog_cmd_i <= '{DEFAULT_ADDRESS, OP_GET_AXIS, 8'h04, 8'h02, 32'h0};
    prog_valid_i <= 1'h1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(posedge clk_i);
      got = prog_ready_o === 1'h1;
    end
    prog_valid_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    check(got && accumulator_o === 32'h0000_C800, "program get");
  endtask
  task automatic t_global;
    logic [7:0] banks [3];
    reply_s r;
    int w;
    banks = '{BANK_MODULE, BANK_USER, BANK_IRQ};
    for (int i = 0; i < 3; i++) begin
      w = u_host.n_wr;
      do_cmd(OP_SET_GLOBAL, 8'h42, banks[i], 32'h1357_0000 + i, 1'h0, r);
      check(r.status === STATUS_OK, "set global");
      check(u_host.n_wr == w + (i == 0), "bank 0 store");
    end
    check(u_host.wr_last === nv_req_s'{2'h0, 8'h42, 32'h1357_0000},
      "bank 0 data");
    for (int i = 0; i < 3; i++) begin
      do_cmd(OP_GET_GLOBAL, 8'h42, banks[i], 32'hFFFF_FFFF, 1'h0, r);
      check(r.value === 32'h1357_0000 + i, "bank data");
      check(accumulator_o === 32'h1357_0000 + i, "acc");
    end
    do_cmd(OP_SET_GLOBAL, 8'h42, 8'h01, 32'h0, 1'h0, r);
    check(r.status === STATUS_BAD_TYPE, "bank 1");
    w = u_host.n_wr;
    do_cmd(OP_PERSIST_GLOBAL, 8'h42, BANK_USER, 32'h0, 1'h0, r);
    check(u_host.n_wr == w + 1 && u_host.wr_last ===
      nv_req_s'{2'h2, 8'h42, 32'h1357_0001}, "persist");
  endtask
  task automatic t_move;
    logic [7:0] sel [4];
    logic [3:0] exp_m [4];
    reply_s r;
    int seen;
    sel = '{8'h01, 8'h85, 8'h47, 8'hC1};
    exp_m = '{4'h4, 4'hA, 4'hF, 4'h0};
    for (int i = 0; i < 4; i++) begin
      seen = mv_seen;
      do_cmd(OP_MOVE_TO_POSITION, MOVE_TYPE_POINT, sel[i], 8 + i,
        1'h0, r);
      if (i < 3) begin
        check(mv_seen == seen + 1 && {mv_last.motors, mv_last.interpolate}
          === exp_m[i] && mv_last.point === 8'(8 + i), "move");
      end else begin
        check(mv_seen == seen && r.status === STATUS_BAD_VALUE,
          "sel");
      end
    end
    do_cmd(OP_MOVE_TO_POSITION, 8'h00, 8'h00, 32'h5, 1'h0, r);
    check(r.status === STATUS_BAD_OPCODE, "move type");
  endtask
  task automatic t_reset;
    reply_s r;
    rst_n_i <= 1'h0;
    auto_restore_i <= 1'h0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    check(restore_busy_o === 1'h0, "restore not asked");
    restore_req_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    restore_req_i <= 1'h0;
    check(restore_busy_o === 1'h1, "restore request");
    for (int i = 0; i < 4000 && restore_busy_o !== 1'h0; i++) @(posedge clk_i);
    do_cmd(OP_GET_GLOBAL, 8'h42, BANK_USER, 32'h0, 1'h0, r);
    check(r.value === 32'h00A5_C342, "restored again");
  endtask
  task automatic give_verdict;
    $display("Mismatches %0d, checks %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'h0;
    rst_n_i = 1'h0;
    prog_valid_i = 1'h0;
    prog_cmd_i = '0;
    auto_restore_i = 1'h1;
    restore_req_i = 1'h0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    t_restore();
    t_axis();
    t_prog();
    t_global();
    t_move();
    t_reset();
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    give_verdict();
  end
endmodule
